// >>> verilog/lsst_pkg.sv
package lsst_pkg;

    // ==========================================================
    // Array geometry and slot timing
    // ==========================================================
    localparam int unsigned LSST_PIXELS = 1024;
    localparam int unsigned LSST_CLKS_PER_PIXEL = 4;
    localparam int unsigned LSST_MIN_START_CLKS = 4104;
    localparam int unsigned LSST_FIFO_DEPTH = 4;
    localparam int unsigned LSST_SAMPLE_W = 12;

    // Counter last, maximum and reset values
    localparam logic [9:0] LSST_PIX_LAST = 10'h3ff;
    localparam logic [1:0] LSST_PHASE_LAST = 2'h3;
    localparam logic [15:0] LSST_PERIOD_RST = 16'h0000;
    localparam logic [15:0] LSST_PERIOD_MAX = 16'hffff;

    // ==========================================================
    // Sequencer states
    // ==========================================================
    typedef enum logic [1:0] {
        LSST_IDLE = 2'b01,
        LSST_SCAN = 2'b10
    } lsst_state_e;

    // One pixel slot leaving the sequencer
    typedef struct packed {
        logic [9:0] index;
        logic high_gain;
        logic [LSST_SAMPLE_W-1:0] sample;
    } lsst_pixel_s;

endpackage : lsst_pkg

// >>> verilog/lsst_fifo.sv
`timescale 1ns/1ps
module lsst_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // ==========================================================
    // Pointer and count update
    // ==========================================================
    always_comb begin
        // Full is a count of DEPTH; the count is one bit wider than the pointers
        push = i_in_valid && (cnt_reg != (AW+1)'(DEPTH));
        pop = (cnt_reg != '0) && i_out_ready;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; contents are qualified by the count
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= i_in_data;
        end
    end

    assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data = mem_reg[rd_reg];

    a_fifo_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count overflow");
endmodule : lsst_fifo

// >>> verilog/lsst_scan.sv
`timescale 1ns/1ps
// How it works
// - Start and clock drive whole scan; a full video buffer holds it
// - Shifting begins at falling edge during start-low
// - One pixel per four clocks, clock bounded
// - Integration time equals start pulse period
// - Each pixel integrates between its own readouts
// - Gain low means high gain, else low
module lsst_scan
    import lsst_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_scan_start_pulse,
    input wire logic i_sensor_clk,
    input wire logic i_gain_select_level,
    input wire logic [LSST_SAMPLE_W-1:0] i_pixel_charge,
    input wire logic i_video_ready,
    output logic o_video_valid,
    output logic [9:0] o_video_index,
    output logic o_video_high_gain,
    output logic [LSST_SAMPLE_W-1:0] o_video_sample,
    output logic o_scanning,
    output logic [15:0] o_start_pulse_period,
    output logic o_start_too_soon,
    output logic o_stalled
);
    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Pins come from the controller's domain: two flops each, a third on the clock and gain pins
    logic [2:0] st_s1_reg, st_s2_reg, st_s1_next, st_s2_next;
    logic clk_d_reg, clk_d_next, gain_reg, gain_next;

    always_comb begin
        st_s1_next = {i_gain_select_level, i_sensor_clk, i_scan_start_pulse};
        st_s2_next = st_s1_reg;
        clk_d_next = st_s2_reg[1];
        gain_next = st_s2_reg[2];
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_s1_reg <= 3'h1;
            st_s2_reg <= 3'h1;
            clk_d_reg <= 1'b0;
            gain_reg <= 1'b0;
        end else begin
            st_s1_reg <= st_s1_next;
            st_s2_reg <= st_s2_next;
            clk_d_reg <= clk_d_next;
            gain_reg <= gain_next;
        end
    end

    logic st_low, clk_fall;
    assign st_low = !st_s2_reg[0];
    assign clk_fall = clk_d_reg && !st_s2_reg[1];

    // ==========================================================
    // Sequencer
    // ==========================================================
    lsst_state_e state_reg, state_next;
    logic [9:0] pix_reg, pix_next;
    logic [1:0] phase_reg, phase_next;
    logic armed_reg, armed_next;
    logic [15:0] per_reg, per_next, last_per_reg, last_per_next;
    logic [15:0] per_inc;
    logic soon_reg, soon_next;
    logic start_evt, slot_evt, fifo_ready, fifo_valid;
    lsst_pixel_s pix_in, pix_out;

    // A start is the first falling clock of each start-low window
    assign start_evt = st_low && clk_fall && armed_reg;

    // Saturating step, so a very long exposure never wraps to a short one
    assign per_inc = (per_reg == LSST_PERIOD_MAX) ? LSST_PERIOD_MAX : per_reg + 1'b1;

    always_comb begin
        state_next = state_reg;
        pix_next = pix_reg;
        phase_next = phase_reg;
        slot_evt = 1'b0;
        // Only one fall per low window counts; re-arm on high
        armed_next = st_low ? (armed_reg && !clk_fall) : 1'b1;
        // Period counted in sensor clocks, saturating
        per_next = clk_fall ? per_inc : per_reg;
        last_per_next = last_per_reg;
        soon_next = soon_reg;
        if (start_evt) begin
            // Exposure is the start period; each pixel restarts at readout
            last_per_next = per_inc;
            per_next = LSST_PERIOD_RST;
            soon_next = (state_reg == LSST_SCAN) ||
                (per_inc < 16'(LSST_MIN_START_CLKS));
        end
        case (state_reg)
            LSST_IDLE: begin
                if (start_evt) begin
                    state_next = LSST_SCAN;
                    pix_next = '0;
                    phase_next = '0;
                end
            end
            LSST_SCAN: begin
                // A start mid-scan is refused; the current scan finishes
                if (clk_fall && fifo_ready) begin
                    phase_next = phase_reg + 1'b1;
                    if (phase_reg == LSST_PHASE_LAST) begin
                        slot_evt = 1'b1;
                        pix_next = pix_reg + 1'b1;
                        if (pix_reg == LSST_PIX_LAST) begin
                            state_next = LSST_IDLE;
                        end
                    end
                end
            end
            default: state_next = LSST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= LSST_IDLE;
            pix_reg <= '0;
            phase_reg <= '0;
            armed_reg <= 1'b1;
            per_reg <= LSST_PERIOD_RST;
            last_per_reg <= LSST_PERIOD_RST;
            soon_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pix_reg <= pix_next;
            phase_reg <= phase_next;
            armed_reg <= armed_next;
            per_reg <= per_next;
            last_per_reg <= last_per_next;
            soon_reg <= soon_next;
        end
    end

    // Gain pin low selects the high-gain conversion
    assign pix_in.index = pix_reg;
    assign pix_in.high_gain = !gain_reg;
    assign pix_in.sample = i_pixel_charge;

    // ==========================================================
    // Video buffer
    // ==========================================================
    // A full buffer holds the slot rather than dropping a pixel
    lsst_fifo #(.WIDTH($bits(lsst_pixel_s)), .DEPTH(LSST_FIFO_DEPTH)) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_in_valid(slot_evt),
        .o_in_ready(fifo_ready),
        .i_in_data(pix_in),
        .o_out_valid(fifo_valid),
        .i_out_ready(i_video_ready && !(o_video_valid && !i_video_ready) || !o_video_valid),
        .o_out_data(pix_out)
    );

    // Output stage registered so every port leaves a flop
    logic vv_reg, vv_next, stall_reg, stall_next;
    lsst_pixel_s vd_reg, vd_next;
    logic take;
    assign take = fifo_valid && (!vv_reg || i_video_ready);

    always_comb begin
        vv_next = take ? 1'b1 : (i_video_ready ? 1'b0 : vv_reg);
        vd_next = take ? pix_out : vd_reg;
        stall_next = (state_reg == LSST_SCAN) && clk_fall && !fifo_ready;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            vv_reg <= 1'b0;
            vd_reg <= '0;
            stall_reg <= 1'b0;
        end else begin
            vv_reg <= vv_next;
            vd_reg <= vd_next;
            stall_reg <= stall_next;
        end
    end

    logic scan_q;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            scan_q <= 1'b0;
        end else begin
            scan_q <= (state_next == LSST_SCAN);
        end
    end

    assign o_video_valid = vv_reg;
    assign o_video_index = vd_reg.index;
    assign o_video_high_gain = vd_reg.high_gain;
    assign o_video_sample = vd_reg.sample;
    assign o_scanning = scan_q;
    assign o_start_pulse_period = last_per_reg;
    assign o_start_too_soon = soon_reg;
    assign o_stalled = stall_reg;

    // ==========================================================
    // Checks
    // ==========================================================
    a_start_enters: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (start_evt && state_reg == LSST_IDLE) |=> state_reg == LSST_SCAN)
        else $error("start did not begin scan");
    a_one_fall_only: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        start_evt |=> !armed_reg)
        else $error("second fall counted as start");
    a_slot_four: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        slot_evt |-> phase_reg == LSST_PHASE_LAST && clk_fall)
        else $error("slot not on fourth clock");
    a_end_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (slot_evt && pix_reg == LSST_PIX_LAST) |=> state_reg == LSST_IDLE)
        else $error("scan did not end at last pixel");
    a_idle_still: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (state_reg == LSST_IDLE && !start_evt) |=> $stable(pix_reg))
        else $error("idle sequencer moved");
    a_gain_map: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        slot_evt |-> pix_in.high_gain == !$past(st_s2_reg[2]))
        else $error("gain mapping wrong");
    a_period_cap: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        start_evt |=> last_per_reg == $past(per_inc))
        else $error("start period not captured");
    a_soon_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (start_evt && state_reg == LSST_SCAN) |=> o_start_too_soon)
        else $error("early start not flagged");
    a_scan_whole: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (state_reg == LSST_SCAN && start_evt) |=> state_reg == LSST_SCAN)
        else $error("scan aborted by start");

    c_scan_start: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        start_evt && state_reg == LSST_IDLE);
    c_scan_end: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        slot_evt && pix_reg == LSST_PIX_LAST);
    c_stall: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) stall_reg);
    c_early: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        start_evt && state_reg == LSST_SCAN);
endmodule : lsst_scan

// >>> verif/lsst_ctl_model.sv
`timescale 1ns/1ps
// ==========================================================
// Controller model: start pin, sensor clock, pixel charge
// ==========================================================
module lsst_ctl_model
    import lsst_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_gain_select_level,
    output logic o_scan_start_pulse,
    output logic o_sensor_clk,
    output logic [LSST_SAMPLE_W-1:0] o_pixel_charge
);
    lsst_pixel_s exp_q[$];
    lsst_pixel_s note;
    int slot = 0;
    int pix = LSST_PIXELS;

    // Pins idle high; sensor clock stands still between frames
    initial begin
        o_scan_start_pulse = 1'b1;
        o_sensor_clk = 1'b1;
        o_pixel_charge = '0;
    end

    // One sensor clock period of 8 ref clocks; far above the real rate to keep runs short
    task automatic fall(input bit st, input bit restart);
        if (slot == 0) begin
            o_pixel_charge = LSST_SAMPLE_W'(pix * 37 + 5); // Stable across the whole slot
        end
        // Start pin only moves in calls that pulse it, so it never toggles twice in one step
        if (st) o_scan_start_pulse = 1'b0;
        repeat (4) @(negedge i_ref_clk);
        o_sensor_clk = 1'b0;
        if (restart) begin
            pix = 0;
            slot = 0;
        end else if (pix < LSST_PIXELS) begin
            slot++;
            if (slot == 4) begin
                note = '{10'(pix), !i_gain_select_level, o_pixel_charge};
                exp_q.push_back(note);
                pix++;
                slot = 0;
            end
        end
        repeat (4) @(negedge i_ref_clk);
        o_sensor_clk = 1'b1;
        if (st) o_scan_start_pulse = 1'b1;
    endtask : fall
endmodule : lsst_ctl_model

// >>> verif/lsst_scan_test.sv
`timescale 1ns/1ps
module lsst_scan_test import lsst_pkg::*;;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_scan_start_pulse, i_sensor_clk;
    logic i_gain_select_level = 1'b0;
    logic [LSST_SAMPLE_W-1:0] i_pixel_charge;
    logic i_video_ready = 1'b0;
    logic o_video_valid, o_video_high_gain, o_scanning, o_start_too_soon, o_stalled;
    logic [9:0] o_video_index;
    logic [9:0] last_idx = 10'h3ff;
    logic [LSST_SAMPLE_W-1:0] o_video_sample;
    logic [15:0] o_start_pulse_period;
    lsst_pixel_s got, want;
    int n_errors = 0;
    int checked = 0;
    int seed = 32'hdb230417;
    bit hold_off = 1'b0;
    bit chk_data = 1'b1;
    bit saw_stall = 1'b0;

    lsst_scan uut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
        .i_scan_start_pulse(i_scan_start_pulse), .i_sensor_clk(i_sensor_clk),
        .i_gain_select_level(i_gain_select_level), .i_pixel_charge(i_pixel_charge),
        .i_video_ready(i_video_ready), .o_video_valid(o_video_valid),
        .o_video_index(o_video_index), .o_video_high_gain(o_video_high_gain),
        .o_video_sample(o_video_sample), .o_scanning(o_scanning),
        .o_start_pulse_period(o_start_pulse_period), .o_start_too_soon(o_start_too_soon),
        .o_stalled(o_stalled));

    lsst_ctl_model ctl (.i_ref_clk(i_ref_clk), .i_gain_select_level(i_gain_select_level),
        .o_scan_start_pulse(i_scan_start_pulse), .o_sensor_clk(i_sensor_clk),
        .o_pixel_charge(i_pixel_charge));

    // ==========================================================
    // Clock, consumer and checking
    // ==========================================================
    initial begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    // Random back-pressure, light enough that the FIFO never fills unless held off
    always @(negedge i_ref_clk) begin
        i_video_ready <= !hold_off && ($random(seed) % 4 != 0);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Oldest note against each pixel taken; order only once falls may have been lost
    always @(posedge i_ref_clk) begin
        if (i_rstn && o_video_valid === 1'b1 && i_video_ready) begin
            got = '{o_video_index, o_video_high_gain, o_video_sample};
            if (chk_data) begin
                want = (ctl.exp_q.size() > 0) ? ctl.exp_q.pop_front() : '1;
                check(got, want, "pixel");
            end else begin
                check(o_video_index, 10'(last_idx + 10'h1), "order");
            end
            last_idx = o_video_index;
        end
        if (o_stalled === 1'b1) saw_stall <= 1'b1;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // Start fall, then n-1 further falls; optional mid-scan start and consumer stall
    task automatic frame(input int n, input logic g, input int per, input int mid);
        @(negedge i_ref_clk);
        i_gain_select_level = g;
        repeat (8) @(negedge i_ref_clk);
        ctl.fall(1'b1, 1'b1);
        repeat (6) @(negedge i_ref_clk);
        check(o_scanning, 1'b1, "scan on");
        if (per != 0) check(o_start_pulse_period, per, "period");
        if (per != 0) check(o_start_too_soon, 1'b0, "spaced start");
        for (int k = 1; k < n; k++) begin
            if (mid != 0 && k == 3000) chk_data = 1'b0;
            hold_off = mid != 0 && k >= 3000 && k < 3060;
            ctl.fall(k == mid, 1'b0);
            if (k == mid) begin
                repeat (4) @(negedge i_ref_clk);
                check(o_start_too_soon, 1'b1, "mid start");
            end
        end
        for (int j = 0; j < 400 && o_scanning === 1'b1; j++) ctl.fall(1'b0, 1'b0);
        repeat (20) @(negedge i_ref_clk);
        check(o_scanning, 1'b0, "idle");
        check(o_video_valid, 1'b0, "no data");
        check(last_idx, 10'h3ff, "last pixel");
        $display("test frame gain %0d done", g);
    endtask : frame

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (10) @(negedge i_ref_clk);
        check({o_video_valid, o_scanning, o_start_too_soon, o_stalled, o_start_pulse_period},
            32'h0, "reset");
        i_rstn = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        frame(LSST_MIN_START_CLKS, 1'b0, 0, 0);
        check(ctl.exp_q.size(), 0, "all pixels");
        frame(LSST_MIN_START_CLKS, 1'b1, LSST_MIN_START_CLKS, 2000);
        check(saw_stall, 1'b1, "stall seen");
        summarize();
    end

    // Watchdog: two frames need about 67000 clocks
    initial begin
        #(4 * 90000);
        n_errors++;
        $display("CHECK FAILED at %0t: timeout", $time);
        summarize();
    end
endmodule : lsst_scan_test
